// ==== logic/mau_regs.vh ====
`ifndef MAU_REGS_VH
`define MAU_REGS_VH
// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define MAU_OPW       16
`define MAU_ACCW      40
`define MAU_PRODW     32
// ----------------------------------------------------------------
// Operation codes on the op port
// ----------------------------------------------------------------
`define MAU_OP_NONE   3'h0
`define MAU_OP_PAR    3'h1
`define MAU_OP_SHIFT  3'h2
`define MAU_OP_IMM    3'h3
`define MAU_OP_MIXED  3'h4
// ----------------------------------------------------------------
// Opcode field positions in the low word
// ----------------------------------------------------------------
`define MAU_PAR_MARK  7
`define MAU_PAR_QHI   6
`define MAU_PAR_QLO   4
`define MAU_PAR_DST   3
`define MAU_PAR_SIGN  2
`define MAU_PAR_ONE   1
`define MAU_PAR_RND   0
`define MAU_MIX_SGN   6
`define MAU_MIX_DST   5
`define MAU_MIX_SIGN  4
// ----------------------------------------------------------------
// Flag positions in the condition flags
// ----------------------------------------------------------------
`define MAU_F_S       7
`define MAU_F_L       6
`define MAU_F_E       5
`define MAU_F_U       4
`define MAU_F_N       3
`define MAU_F_Z       2
`define MAU_F_V       1
`define MAU_F_C       0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MAU_ACC_RST   40'h00_0000_0000
`define MAU_FLAG_RST  8'h00
`endif

// ==== logic/mau_mult.v ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Signed or unsigned 16 by 16 multiplier
// ----------------------------------------------------------------
module mau_mult (
  a,
  b,
  a_signed,
  b_signed,
  prod
);
  input  wire [15:0] a;
  input  wire [15:0] b;
  input  wire        a_signed;
  input  wire        b_signed;
  output wire [31:0] prod;

  wire signed [16:0] ax;
  wire signed [16:0] bx;
  wire signed [33:0] full;

  assign ax   = {a_signed & a[15], a};
  assign bx   = {b_signed & b[15], b};
  assign full = ax * bx;
  assign prod = full[31:0];
endmodule // mau_mult

// ==== logic/mau_round.v ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Rounding of a 40-bit value at bit 16, low bits cleared
// ----------------------------------------------------------------
module mau_round (
  din,
  convergent,
  dout
);
  input  wire [39:0] din;
  input  wire        convergent;
  output reg  [39:0] dout;

  reg [40:0] sum;

  always @* begin
    sum = {din[39], din} + 41'h000_0000_8000;
    // Convergent rounding breaks an exact tie toward an even result.
    if (convergent && (din[15:0] == 16'h8000)) begin
      sum[16] = 1'b0;
    end
    dout = {sum[39:16], 16'h0000};
  end
endmodule // mau_round

// ==== logic/mau_top.v ====
`timescale 1ns/100ps
`include "mau_regs.vh"
module mau_top (
  clk,
  rstn,
  op_valid,
  op_kind,
  opcode,
  ext_word,
  x0,
  x1,
  y0,
  y1,
  dp_mode,
  round_convergent,
  scale_mode,
  flags_in,
  acc_a,
  acc_b,
  flags,
  done,
  bad_opcode,
  dp_step
);
  input  wire        clk;
  input  wire        rstn;
  input  wire        op_valid;
  input  wire [2:0]  op_kind;
  input  wire [23:0] opcode;
  input  wire [15:0] ext_word;
  input  wire [15:0] x0;
  input  wire [15:0] x1;
  input  wire [15:0] y0;
  input  wire [15:0] y1;
  input  wire        dp_mode;
  input  wire        round_convergent;
  input  wire [1:0]  scale_mode;
  input  wire [7:0]  flags_in;
  output reg  [39:0] acc_a;
  output reg  [39:0] acc_b;
  output reg  [7:0]  flags;
  output reg         done;
  output reg         bad_opcode;
  output reg         dp_step;

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  reg  [15:0] opa;
  reg  [15:0] opb;
  reg         a_sgn;
  reg         b_sgn;
  reg         dst_b;
  reg         minus;
  reg         rnd;
  reg         legal;
  reg         dp_pair;
  reg  [2:0]  source_pair_select3;
  reg  [3:0]  source_pair_select4;
  reg  [1:0]  immediate_form_source_select;
  reg  [3:0]  shift_n;

  function [15:0] reg_pick;
    input [1:0] code;
    input [15:0] r0;
    input [15:0] r1;
    input [15:0] r2;
    input [15:0] r3;
    begin
      case (code)
        2'h0:    reg_pick = r0;
        2'h1:    reg_pick = r1;
        2'h2:    reg_pick = r2;
        default: reg_pick = r3;
      endcase
    end
  endfunction

  always @* begin
    opa   = 16'h0000;
    opb   = 16'h0000;
    a_sgn = 1'b1;
    b_sgn = 1'b1;
    dst_b = 1'b0;
    minus = 1'b0;
    rnd   = 1'b0;
    legal = 1'b0;
    dp_pair = 1'b0;
    source_pair_select3 = opcode[`MAU_PAR_QHI:`MAU_PAR_QLO];
    source_pair_select4 = opcode[3:0];
    immediate_form_source_select = opcode[5:4];
    shift_n = opcode[11:8];
    case (op_kind)
      `MAU_OP_PAR: begin
        legal = opcode[`MAU_PAR_MARK] & opcode[`MAU_PAR_ONE];
        dst_b = opcode[`MAU_PAR_DST];
        minus = opcode[`MAU_PAR_SIGN];
        rnd   = opcode[`MAU_PAR_RND];
        case (source_pair_select3)
          3'h0: begin
            opa = x0;
            opb = x0;
          end
          3'h1: begin
            opa = y0;
            opb = y0;
          end
          3'h2: begin
            opa = x1;
            opb = x0;
          end
          3'h3: begin
            opa = y1;
            opb = y0;
          end
          3'h4: begin
            opa = x0;
            opb = y1;
          end
          3'h5: begin
            opa = y0;
            opb = x0;
          end
          3'h6: begin
            opa = x1;
            opb = y0;
          end
          default: begin
            opa = y1;
            opb = x1;
          end
        endcase
        // With dp_mode set, pairs X1*Y0, X0*Y1, Y1*X1 serve only the double-precision sequence.
        dp_pair = dp_mode && ((source_pair_select3 == 3'h4) || (source_pair_select3 == 3'h6)
                  || (source_pair_select3 == 3'h7));
      end
      `MAU_OP_SHIFT: begin
        legal = 1'b1;
        dst_b = opcode[3];
        minus = opcode[2];
        rnd   = opcode[0];
        opa   = reg_pick(opcode[5:4], y1, x0, y0, x1);
        // The immediate two to minus n is an unsigned fraction.
        opb   = 16'h8000 >> shift_n;
        b_sgn = 1'b0;
      end
      `MAU_OP_IMM: begin
        legal = 1'b1;
        dst_b = opcode[3];
        minus = opcode[2];
        rnd   = opcode[0];
        opa   = ext_word;
        opb   = reg_pick(immediate_form_source_select, x0, y0, x1, y1);
      end
      `MAU_OP_MIXED: begin
        legal = 1'b1;
        dst_b = opcode[`MAU_MIX_DST];
        minus = opcode[`MAU_MIX_SIGN];
        a_sgn = ~opcode[`MAU_MIX_SGN];
        b_sgn = 1'b0;
        opa   = reg_pick(source_pair_select4[3:2], x0, x1, y0, y1);
        opb   = reg_pick(source_pair_select4[1:0], x0, x1, y0, y1);
      end
      default: begin
        legal = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Multiply, accumulate, round
  // ----------------------------------------------------------------
  wire [31:0] prod;
  wire [39:0] rounded;
  reg  [39:0] prod_ext;
  reg  [39:0] acc_src;
  reg  [39:0] sum;
  reg  [39:0] result;
  reg  [40:0] wide;
  reg         ovf;
  reg         prod_neg;

  mau_mult u_mult (
    .a        (opa),
    .b        (opb),
    .a_signed (a_sgn),
    .b_signed (b_sgn),
    .prod     (prod)
  );

  always @* begin
    // Unsigned products are zero-extended, signed ones sign-extended.
    prod_neg = (a_sgn | b_sgn) && prod[31] && (a_sgn & b_sgn | opa[15] & a_sgn);
    prod_ext = prod_neg ? {8'hff, prod} : {8'h00, prod};
    if (minus) begin
      prod_ext = ~prod_ext + 40'h00_0000_0001;
    end
    acc_src = dst_b ? acc_b : acc_a;
    wide    = {acc_src[39], acc_src} + {prod_ext[39], prod_ext};
    sum     = wide[39:0];
    ovf     = wide[40] ^ wide[39];
    result  = rnd ? rounded : sum;
  end

  mau_round u_round (
    .din        (sum),
    .convergent (round_convergent),
    .dout       (rounded)
  );

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  reg [7:0] flags_nxt;
  reg       scale_bit;
  reg       ext_flag;
  reg       unnorm_flag;
  reg       neg_flag;
  reg       zero_flag;
  reg       limit_flag;

  always @* begin
    case (scale_mode)
      2'h1: begin
        scale_bit = result[31] ^ result[30];
      end
      2'h2: begin
        scale_bit = result[33] ^ result[32];
      end
      default: begin
        scale_bit = result[32] ^ result[31];
      end
    endcase
    // Extension is set while bits 39 to 31 do not all agree.
    ext_flag    = ~((&result[39:31]) | ~(|result[39:31]));
    unnorm_flag = ~(result[32] ^ result[31]);
    neg_flag    = result[39];
    zero_flag   = (result == 40'h00_0000_0000);
    limit_flag  = flags_in[`MAU_F_L] | ovf;
    flags_nxt = flags_in;
    flags_nxt[`MAU_F_S] = flags_in[`MAU_F_S] | scale_bit;
    flags_nxt[`MAU_F_L] = limit_flag;
    flags_nxt[`MAU_F_E] = ext_flag;
    flags_nxt[`MAU_F_U] = unnorm_flag;
    flags_nxt[`MAU_F_N] = neg_flag;
    flags_nxt[`MAU_F_Z] = zero_flag;
    flags_nxt[`MAU_F_V] = ovf;
    flags_nxt[`MAU_F_C] = flags_in[`MAU_F_C];
  end

  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  wire accept;
  wire refuse;
  wire dp_hold;

  assign accept  = op_valid & legal & ~dp_pair;
  assign refuse  = op_valid & ~legal;
  assign dp_hold = op_valid & legal & dp_pair;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_a      <= `MAU_ACC_RST;
      acc_b      <= `MAU_ACC_RST;
      flags      <= `MAU_FLAG_RST;
      done       <= 1'b0;
      bad_opcode <= 1'b0;
      dp_step    <= 1'b0;
    end else begin
      done       <= accept;
      bad_opcode <= refuse;
      dp_step    <= dp_hold;
      // Refused and double-precision ops leave the accumulators alone.
      if (accept) begin
        if (dst_b) begin
          acc_b <= result;
        end else begin
          acc_a <= result;
        end
        flags <= flags_nxt;
      end
    end
  end
endmodule // mau_top

// ==== verification/mau_checker.sv ====
`timescale 1ns/100ps
module mau_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        op_valid,
  input wire logic [2:0]  op_kind,
  input wire logic [23:0] opcode,
  input wire logic [7:0]  flags_in,
  input wire logic [39:0] acc_a,
  input wire logic [39:0] acc_b,
  input wire logic [7:0]  flags,
  input wire logic        done,
  input wire logic        bad_opcode,
  input wire logic        dp_step
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_ANSWER: assert property (op_valid |=> done || bad_opcode || dp_step)
    else $error("no answer after op");
  AST_IDLE: assert property (!op_valid |=> !done && !bad_opcode && !dp_step)
    else $error("pulse without op");
  AST_ILLEGAL: assert property (op_valid && op_kind == 3'h0 |=> bad_opcode && $stable(acc_a))
    else $error("illegal op not refused");
  AST_CARRY: assert property (done |-> flags[0] == $past(flags_in[0]))
    else $error("carry changed");
  AST_NEG: assert property (done && $past(op_kind) == 3'h3 && !$past(opcode[3]) |-> flags[3] == acc_a[39])
    else $error("negative flag wrong");
  AST_ZERO: assert property (done && $past(op_kind) == 3'h4 && $past(opcode[5]) |-> flags[2] == (acc_b == 40'h00_0000_0000))
    else $error("zero flag wrong");
  AST_DP: assert property (dp_step |-> $stable(acc_a) && $stable(acc_b))
    else $error("double precision pair written");
  AST_RND: assert property (done && $past(op_kind) == 3'h1 && $past(opcode[0]) |-> ($past(opcode[3]) ? acc_b[15:0] : acc_a[15:0]) == 16'h0000)
    else $error("low bits not cleared");
  AST_DST: assert property (done && $past(op_kind) == 3'h1 && $past(opcode[3]) |-> $stable(acc_a))
    else $error("wrong accumulator written");
endmodule // mau_checker
bind mau_top mau_checker u_chk (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_kind(op_kind),
  .opcode(opcode), .flags_in(flags_in), .acc_a(acc_a), .acc_b(acc_b), .flags(flags),
  .done(done), .bad_opcode(bad_opcode), .dp_step(dp_step));

// ==== verification/mau_core_model.sv ====
`timescale 1ns/100ps
module mau_core_model (
  output logic [15:0] x0,
  output logic [15:0] x1,
  output logic [15:0] y0,
  output logic [15:0] y1,
  output wire  [7:0]  flags_in,
  input  wire  [7:0]  flags
);
  initial begin
    set(16'h0000, 16'h0000, 16'h0000, 16'h0000);
  end
  // Flags are fed back with the carry held set.
  assign flags_in = {flags[7:1], 1'b1};
  task set(input [15:0] a, input [15:0] b, input [15:0] c, input [15:0] d);
    x0 = a;
    x1 = b;
    y0 = c;
    y1 = d;
  endtask
endmodule // mau_core_model

// ==== verification/tb.sv ====
`timescale 1ns/100ps
module tb;
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         op_valid = 1'b0;
  reg  [2:0]  op_kind = 3'h0;
  reg  [23:0] opcode = 24'h00_0000;
  reg  [15:0] ext_word = 16'h0000;
  reg         dp_mode = 1'b0;
  reg         round_convergent = 1'b0;
  reg  [1:0]  scale_mode = 2'h0;
  wire [15:0] x0, x1, y0, y1;
  wire [7:0]  flags_in, flags;
  wire [39:0] acc_a, acc_b;
  wire        done, bad_opcode, dp_step;
  integer     bad_count = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  always #20 clk = ~clk;
  mau_core_model u_core (.x0(x0), .x1(x1), .y0(y0), .y1(y1), .flags_in(flags_in), .flags(flags));
  mau_top u_dut (.clk(clk), .rstn(rstn), .op_valid(op_valid), .op_kind(op_kind),
    .opcode(opcode), .ext_word(ext_word), .x0(x0), .x1(x1), .y0(y0), .y1(y1),
    .dp_mode(dp_mode), .round_convergent(round_convergent), .scale_mode(scale_mode),
    .flags_in(flags_in), .acc_a(acc_a), .acc_b(acc_b), .flags(flags), .done(done),
    .bad_opcode(bad_opcode), .dp_step(dp_step));
  // ----
  // Tasks
  // ----
  task chk(input [63:0] nm, input [39:0] exp, input [39:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("FAIL %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task op(input [2:0] k, input [23:0] c, input [15:0] e);
    @(posedge clk);
    #1;
    op_valid = 1'b1;
    op_kind = k;
    opcode = c;
    ext_word = e;
    @(posedge clk);
    #1;
    op_valid = 1'b0;
  endtask
  task stop_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task t_par;
    u_core.set(16'h0003, 16'h0000, 16'hFFFE, 16'h0000);
    op(3'h1, 24'h00_0082, 16'h0000);
    chk("done", 40'h1, done);
    chk("acc_a", 40'h00_0000_0009, acc_a);
    op(3'h1, 24'h00_009E, 16'h0000);
    chk("acc_b", 40'hFF_FFFF_FFFC, acc_b);
    chk("neg", 40'h1, flags[3]);
    $display("par test done");
  endtask
  task t_rnd;
    round_convergent = 1'b1;
    u_core.set(16'h0100, 16'h0000, 16'hFFFE, 16'h0000);
    op(3'h1, 24'h00_0083, 16'h0000);
    chk("acc_a", 40'h00_0001_0000, acc_a);
    u_core.set(16'h0080, 16'h0100, 16'hFFFE, 16'h0000);
    op(3'h1, 24'h00_00A3, 16'h0000);
    chk("acc_a", 40'h00_0002_0000, acc_a);
    op(3'h1, 24'h00_00A3, 16'h0000);
    chk("acc_a", 40'h00_0002_0000, acc_a);
    round_convergent = 1'b0;
    op(3'h1, 24'h00_00A3, 16'h0000);
    chk("acc_a", 40'h00_0003_0000, acc_a);
    $display("rnd test done");
  endtask
  task t_imm;
    u_core.set(16'h0100, 16'h0005, 16'hFFFE, 16'h0000);
    op(3'h3, 24'h00_0020, 16'hFFFF);
    chk("acc_a", 40'h00_0002_FFFB, acc_a);
    $display("imm test done");
  endtask
  task t_mix;
    u_core.set(16'hFFFF, 16'h0002, 16'hFFFE, 16'h0000);
    scale_mode = 2'h2;
    op(3'h4, 24'h00_0060, 16'h0000);
    chk("acc_b", 40'h00_FFFD_FFFD, acc_b);
    chk("flags", 40'h21, flags);
    scale_mode = 2'h0;
    op(3'h4, 24'h00_0020, 16'h0000);
    chk("acc_b", 40'h00_FFFC_FFFE, acc_b);
    chk("flags", 40'hA1, flags);
    $display("mix test done");
  endtask
  task t_shift;
    op(3'h2, 24'h00_0118, 16'h0000);
    chk("acc_b", 40'h00_FFFC_BFFE, acc_b);
    $display("shift test done");
  endtask
  task t_bad;
    op(3'h0, 24'h00_0000, 16'h0000);
    chk("bad", 40'h1, bad_opcode);
    op(3'h1, 24'h00_0080, 16'h0000);
    chk("bad", 40'h1, bad_opcode);
    chk("acc_a", 40'h00_0002_FFFB, acc_a);
    $display("bad test done");
  endtask
  task t_dp;
    dp_mode = 1'b1;
    op(3'h1, 24'h00_00C2, 16'h0000);
    chk("dp_step", 40'h1, dp_step);
    chk("acc_a", 40'h00_0002_FFFB, acc_a);
    dp_mode = 1'b0;
    $display("dp test done");
  endtask
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      bad_count = bad_count + 1;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_par;
    t_rnd;
    t_imm;
    t_mix;
    t_shift;
    t_bad;
    t_dp;
    stop_test;
  end
endmodule // tb
